// ### logic/dior_top.sv
// How it works
// R01: Routing mode is active only while the routing-enable entry equals one.
// R02: Routing table entry n selects the source of input word bit n-1.
// R03: Codes decode to constant zero, physical inputs 1-16, Hall U-W, encoder A/B/index.
// R04: Bit 7 of a code inverts the selected source; 0x80 is constant one.
// R05: Enabling routing loads the table with codes that reproduce the prior behaviour.
// R06: Software should not toggle repeatedly between normal and routing modes.
// R07: Bit 0 carries input 1 negative limit; bit 16 carries its full level.
// R08: Output pin n follows bit 15+n of the output word.
// R09: Low output word bits are special functions; only bit 0, the brake, is used.
// R10: Each of the first four I/O pins may be driven as an output.
// R11: Normally closed polarity turns a one into a low pin level; at the brake pin a one instead releases the pin high.
// R12: Manual override drives an output, brake included, from the manual value bit.
// R13: Each modifier bit acts only on the output at its own position.
// R14: The first and fifth output configuration entries have no effect.
// R15: Inputs are sampled once per millisecond.
// R16: Special enable mask bits 0-2 gate limit and home; bits 16-31 unaffected.
// R17: A force-enable bit replaces the sampled level with the force value bit.
// R18: After reset modifier registers read zero and routing is disabled.
// R19: Undefined source codes read as constant zero, or one with bit 7 set.
`timescale 1ns/1ns
`default_nettype none
module dior_top
  import dior_pkg::*;
#(
  parameter int SAMPLE_CYC = DIOR_SAMPLE_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pins
  input wire logic [15:0] i_phys_in,
  input wire logic [2:0] i_hall,
  input wire logic [2:0] i_enc,
  input wire logic [3:0] i_pin_is_out,
  output logic [3:0] o_dio_out,
  output logic [3:0] o_dio_oe_n,
  output logic o_brake_out,
  output logic o_brake_oe_n,
  // Object access
  input wire logic i_od_wr,
  input wire logic i_od_rd,
  input wire logic [15:0] i_od_index,
  input wire logic [7:0] i_od_sub,
  input wire logic [31:0] i_od_wdata,
  output logic [31:0] o_od_rdata,
  output logic o_od_ack,
  output logic o_od_err,
  // Status
  output logic [31:0] o_input_word,
  output logic o_routing_on
);
  // ********************************
  // Helpers
  // ********************************
  function automatic logic route_bit(input logic [7:0] c, input logic [15:0] l,
                                     input logic [2:0] h, input logic [2:0] e);
    logic [6:0] s;
    logic v;
    s = c[6:0];
    v = 1'b0;
    if (s >= DIOR_SRC_PHYS_LO && s <= DIOR_SRC_PHYS_HI) begin
      v = l[4'(s - DIOR_SRC_PHYS_LO)]; // R03
    end else if (s >= DIOR_SRC_HALL_U && s <= DIOR_SRC_HALL_W) begin
      v = h[2'(s - DIOR_SRC_HALL_U)]; // R03
    end else if (s >= DIOR_SRC_ENC_A && s <= DIOR_SRC_ENC_I) begin
      v = e[2'(s - DIOR_SRC_ENC_A)]; // R03
    end
    return v ^ c[7]; // R04 R19
  endfunction : route_bit

  function automatic logic hit(input logic [15:0] idx, input logic [7:0] sub);
    return i_od_index == idx && i_od_sub == sub;
  endfunction : hit

  // ********************************
  // Sampling
  // ********************************
  logic [31:0] cnt_reg;
  logic tick;
  logic [15:0] raw_reg;
  logic [2:0] hall_reg;
  logic [2:0] enc_reg;

  assign tick = cnt_reg == 32'(SAMPLE_CYC - 1);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 32'h0;
    end else if (tick) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end

  // Pulses shorter than the sample period can be missed entirely
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      raw_reg <= 16'h0;
      hall_reg <= 3'h0;
      enc_reg <= 3'h0;
    end else if (tick) begin
      raw_reg <= i_phys_in; // R15
      hall_reg <= i_hall;
      enc_reg <= i_enc;
    end
  end

  // ********************************
  // Configuration registers
  // ********************************
  logic [15:0] sfe_reg;
  logic [15:0] inv_reg;
  logic [15:0] fen_reg;
  logic [15:0] fval_reg;
  logic [7:0] ren_reg;
  logic [7:0] tbl_reg [32];
  logic [31:0] owd_reg;
  logic [31:0] pol_reg;
  logic [31:0] men_reg;
  logic [31:0] mval_reg;
  logic routing;
  logic route_load;
  logic tbl_wr;

  assign routing = ren_reg == DIOR_ROUTE_ON; // R01
  assign o_routing_on = routing;
  assign route_load = i_od_wr && hit(DIOR_IDX_IN_CFG, DIOR_SUB_8) &&
                      i_od_wdata[7:0] == DIOR_ROUTE_ON && !routing;
  assign tbl_wr = i_od_wr && i_od_index == DIOR_IDX_ROUTE_TBL &&
                  i_od_sub >= DIOR_SUB_1 && i_od_sub <= DIOR_SUB_TBL_LAST;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sfe_reg <= 16'h0;
      inv_reg <= 16'h0;
      fen_reg <= 16'h0;
      fval_reg <= 16'h0;
      ren_reg <= 8'h0; // R18
    end else if (i_od_wr && i_od_index == DIOR_IDX_IN_CFG) begin
      case (i_od_sub)
        DIOR_SUB_1: sfe_reg <= i_od_wdata[15:0];
        DIOR_SUB_2: inv_reg <= i_od_wdata[15:0];
        DIOR_SUB_3: fen_reg <= i_od_wdata[15:0];
        DIOR_SUB_4: fval_reg <= i_od_wdata[15:0];
        DIOR_SUB_8: ren_reg <= i_od_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Table reload on enable keeps the inputs seamless across the switch
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 32; i++) begin
        tbl_reg[i] <= DIOR_SRC_ZERO;
      end
    end else if (route_load) begin
      for (int i = 0; i < 32; i++) begin
        if (i >= DIOR_LVL_LSB) begin
          tbl_reg[i] <= 8'(i - DIOR_LVL_LSB + 1); // R05
        end else if (i < DIOR_NUM_SPECIAL && sfe_reg[i]) begin
          tbl_reg[i] <= 8'(i + 1); // R05
        end else begin
          tbl_reg[i] <= DIOR_SRC_ZERO;
        end
      end
    end else if (tbl_wr) begin
      tbl_reg[5'(i_od_sub - DIOR_SUB_1)] <= i_od_wdata[7:0]; // R02
    end
  end

  // Entries one and five are accepted and dropped
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      owd_reg <= DIOR_RST_WORD;
      pol_reg <= DIOR_RST_WORD; // R18
      men_reg <= DIOR_RST_WORD;
      mval_reg <= DIOR_RST_WORD;
    end else if (i_od_wr) begin
      if (hit(DIOR_IDX_OUT_WORD, DIOR_SUB_1)) begin
        owd_reg <= i_od_wdata;
      end
      if (i_od_index == DIOR_IDX_OUT_CFG) begin
        case (i_od_sub)
          DIOR_SUB_2: pol_reg <= i_od_wdata;
          DIOR_SUB_3: men_reg <= i_od_wdata;
          DIOR_SUB_4: mval_reg <= i_od_wdata;
          default: ; // R14
        endcase
      end
    end
  end

  // ********************************
  // Input word
  // ********************************
  logic [15:0] lvl;
  logic [31:0] def_word;
  logic [31:0] rte_word;

  assign lvl = (fen_reg & fval_reg) | (~fen_reg & (raw_reg ^ inv_reg)); // R17
  assign def_word = {lvl, 13'h0, lvl[2:0] & sfe_reg[2:0]}; // R07 R16

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      rte_word[i] = route_bit(tbl_reg[i], lvl, hall_reg, enc_reg); // R02
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_input_word <= DIOR_RST_WORD;
    end else begin
      o_input_word <= routing ? rte_word : def_word; // R01
    end
  end

  // ********************************
  // Outputs
  // ********************************
  logic [31:0] eff;

  // Manual override bypasses polarity so software sets the DIO pin levels directly; a manual one pulls the brake pin low
  assign eff = (men_reg & mval_reg) | (~men_reg & (owd_reg ^ pol_reg)); // R11 R12 R13

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dio_out <= 4'h0;
      o_dio_oe_n <= 4'hf;
      o_brake_oe_n <= 1'b1;
    end else begin
      o_dio_out <= eff[DIOR_LVL_LSB +: DIOR_NUM_IO]; // R08
      o_dio_oe_n <= ~i_pin_is_out; // R10
      o_brake_oe_n <= ~eff[DIOR_BRAKE_BIT]; // R09
    end
  end

  // Open drain: the brake pin is only ever pulled low
  assign o_brake_out = 1'b0;

  // ********************************
  // Read-back
  // ********************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_od_rdata <= 32'h0;
      o_od_ack <= 1'b0;
      o_od_err <= 1'b0;
    end else begin
      o_od_ack <= i_od_rd || i_od_wr;
      o_od_err <= 1'b0;
      o_od_rdata <= 32'h0;
      if (i_od_rd) begin
        if (hit(DIOR_IDX_IN_CFG, DIOR_SUB_1)) o_od_rdata <= 32'(sfe_reg);
        else if (hit(DIOR_IDX_IN_CFG, DIOR_SUB_2)) o_od_rdata <= 32'(inv_reg);
        else if (hit(DIOR_IDX_IN_CFG, DIOR_SUB_3)) o_od_rdata <= 32'(fen_reg);
        else if (hit(DIOR_IDX_IN_CFG, DIOR_SUB_4)) o_od_rdata <= 32'(fval_reg);
        else if (hit(DIOR_IDX_IN_CFG, DIOR_SUB_5)) o_od_rdata <= 32'(raw_reg);
        else if (hit(DIOR_IDX_IN_CFG, DIOR_SUB_8)) o_od_rdata <= 32'(ren_reg);
        else if (tbl_wr || (i_od_index == DIOR_IDX_ROUTE_TBL && i_od_sub >= DIOR_SUB_1
                 && i_od_sub <= DIOR_SUB_TBL_LAST))
          o_od_rdata <= 32'(tbl_reg[5'(i_od_sub - DIOR_SUB_1)]);
        else if (hit(DIOR_IDX_IN_WORD, DIOR_SUB_1)) o_od_rdata <= o_input_word;
        else if (hit(DIOR_IDX_OUT_WORD, DIOR_SUB_1)) o_od_rdata <= owd_reg;
        else if (hit(DIOR_IDX_OUT_CFG, DIOR_SUB_2)) o_od_rdata <= pol_reg;
        else if (hit(DIOR_IDX_OUT_CFG, DIOR_SUB_3)) o_od_rdata <= men_reg;
        else if (hit(DIOR_IDX_OUT_CFG, DIOR_SUB_4)) o_od_rdata <= mval_reg;
        else if (!hit(DIOR_IDX_OUT_CFG, DIOR_SUB_1) && !hit(DIOR_IDX_OUT_CFG, DIOR_SUB_5))
          o_od_err <= 1'b1;
      end
    end
  end

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_route_on;
    route_load;
  endsequence
  sequence s_table_ready;
    routing && tbl_reg[DIOR_LVL_LSB] == 8'h01 && !tbl_wr;
  endsequence

  AST_ROUTE_OFF_DEFAULT: assert property (!routing |=> o_input_word == $past(def_word)) // R01
    else $error("Input word differs from default mapping");
  AST_LOAD_ON_ENABLE: assert property (s_route_on |=> routing && tbl_reg[16] == 8'h01
    && tbl_reg[31] == 8'h10) // R05
    else $error("Routing table not loaded on enable");
  AST_ROUTE_INPUT1: assert property (s_table_ready |=> o_input_word[16] == $past(lvl[0])) // R03
    else $error("Routed input 1 not on bit 16");
  AST_CONST_ONE: assert property (routing && tbl_reg[0] == 8'h80 && !tbl_wr
    |=> o_input_word[0]) // R04
    else $error("Code 0x80 does not read as one");
  AST_OUT1_POLARITY: assert property (!men_reg[16] |=> o_dio_out[0] ==
    ($past(owd_reg[16]) ^ $past(pol_reg[16]))) // R11
    else $error("Output 1 level wrong");
  AST_BRAKE_MANUAL: assert property (men_reg[0] |=> o_brake_oe_n == !$past(mval_reg[0])) // R12
    else $error("Brake ignores manual value");
  AST_SAMPLE_HOLD: assert property (!tick |=> $stable(raw_reg)) // R15
    else $error("Inputs sampled off the millisecond tick");
  AST_COMPAT_IGNORED: assert property (i_od_wr && hit(DIOR_IDX_OUT_CFG, DIOR_SUB_5)
    |=> $stable(eff) ##1 $stable(o_brake_oe_n)) // R14
    else $error("Compatibility entry altered outputs");
  AST_SPECIAL_MASK: assert property (!routing && !sfe_reg[0] |=> !o_input_word[0]) // R16
    else $error("Masked special function still set");
endmodule : dior_top
`default_nettype wire

// ### logic/dior_pkg.sv
`default_nettype none
package dior_pkg;
  // ********************************
  // Object indices and subindices
  // ********************************
  localparam logic [15:0] DIOR_IDX_IN_CFG = 16'h3240;
  localparam logic [15:0] DIOR_IDX_ROUTE_TBL = 16'h3242;
  localparam logic [15:0] DIOR_IDX_OUT_CFG = 16'h3250;
  localparam logic [15:0] DIOR_IDX_IN_WORD = 16'h60fd;
  localparam logic [15:0] DIOR_IDX_OUT_WORD = 16'h60fe;
  localparam logic [7:0] DIOR_SUB_1 = 8'h01;
  localparam logic [7:0] DIOR_SUB_2 = 8'h02;
  localparam logic [7:0] DIOR_SUB_3 = 8'h03;
  localparam logic [7:0] DIOR_SUB_4 = 8'h04;
  localparam logic [7:0] DIOR_SUB_5 = 8'h05;
  localparam logic [7:0] DIOR_SUB_8 = 8'h08;
  localparam logic [7:0] DIOR_SUB_TBL_LAST = 8'h20;
  localparam logic [7:0] DIOR_ROUTE_ON = 8'h01;
  // ********************************
  // Routing source codes
  // ********************************
  localparam logic [6:0] DIOR_SRC_PHYS_LO = 7'h01;
  localparam logic [6:0] DIOR_SRC_PHYS_HI = 7'h10;
  localparam logic [6:0] DIOR_SRC_HALL_U = 7'h41;
  localparam logic [6:0] DIOR_SRC_HALL_W = 7'h43;
  localparam logic [6:0] DIOR_SRC_ENC_A = 7'h44;
  localparam logic [6:0] DIOR_SRC_ENC_I = 7'h46;
  localparam logic [7:0] DIOR_SRC_ZERO = 8'h00;
  localparam logic [7:0] DIOR_SRC_ONE = 8'h80;
  // ********************************
  // Word layout
  // ********************************
  localparam int DIOR_LVL_LSB = 16;
  localparam int DIOR_NUM_SPECIAL = 3;
  localparam int DIOR_NUM_IO = 4;
  localparam int DIOR_BRAKE_BIT = 0;
  localparam logic [31:0] DIOR_RST_WORD = 32'h0000_0000;
  // ********************************
  // Timing
  // ********************************
  localparam int DIOR_CLK_NS = 10;
  localparam int DIOR_SAMPLE_NS = 1000000;
  localparam int DIOR_SAMPLE_CYC = DIOR_SAMPLE_NS / DIOR_CLK_NS;
endpackage : dior_pkg
`default_nettype wire

// ### verif/dior_field.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// Switches, sensors and loads
// ****************
module dior_field (
  // Clock
  input wire logic i_clk,
  // Wanted levels: phys 0..15, hall 16..18, encoder 19..21
  input wire logic [21:0] i_lvl,
  // Device pins
  input wire logic [3:0] i_dio_out,
  input wire logic [3:0] i_dio_oe_n,
  input wire logic i_brake_out,
  input wire logic i_brake_oe_n,
  // Levels seen
  output logic [15:0] o_phys,
  output logic [2:0] o_hall,
  output logic [2:0] o_enc,
  output logic [3:0] o_pin,
  output logic o_brake_pin
);
  // Levels only move on the clock and stay put for many ticks
  always_ff @(posedge i_clk) begin
    {o_enc, o_hall, o_phys} <= i_lvl;
  end
  // Loads pull down a released pin; the brake supply pulls its drain up
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_pin[k] = i_dio_oe_n[k] ? 1'b0 : i_dio_out[k];
    end
    o_brake_pin = i_brake_oe_n ? 1'b1 : i_brake_out;
  end
endmodule : dior_field
`default_nettype wire

// ### verif/dior_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dior_top_tb;
  import dior_pkg::*;
  localparam int SC = 10;
  logic i_clk, i_rst_n, wr, rd, ack, err, re, ron, bk, bkoe, bpin;
  logic [15:0] ix, ph;
  logic [7:0] sb;
  logic [31:0] wd, rdat, iw, rv;
  logic [2:0] hl, en;
  logic [3:0] pio, dout, doe, pin;
  logic [21:0] lv;
  int errors, compares, seed, b;
  bit [31:0] owd, pol, men, mval, msk, inv, fen, fv;
  bit [7:0] tbl [32];
  bit rte;
  dior_top #(.SAMPLE_CYC(SC)) u_dior_top (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_phys_in(ph), .i_hall(hl), .i_enc(en), .i_pin_is_out(pio), .o_dio_out(dout),
    .o_dio_oe_n(doe), .o_brake_out(bk), .o_brake_oe_n(bkoe), .i_od_wr(wr),
    .i_od_rd(rd), .i_od_index(ix), .i_od_sub(sb), .i_od_wdata(wd),
    .o_od_rdata(rdat), .o_od_ack(ack), .o_od_err(err), .o_input_word(iw),
    .o_routing_on(ron));
  dior_field u_dior_field (.i_clk(i_clk), .i_lvl(lv), .i_dio_out(dout),
    .i_dio_oe_n(doe), .i_brake_out(bk), .i_brake_oe_n(bkoe), .o_phys(ph),
    .o_hall(hl), .o_enc(en), .o_pin(pin), .o_brake_pin(bpin));
  initial begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  task report_and_stop();
    $display("checks %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // ****************
  // Object access and model
  // ****************
  task od(bit w, logic [15:0] x, logic [7:0] s, logic [31:0] d);
    int n;
    @(posedge i_clk);
    wr <= w;
    rd <= !w;
    ix <= x;
    sb <= s;
    wd <= d;
    @(posedge i_clk);
    wr <= 0;
    rd <= 0;
    #1;
    n = 0;
    while (ack !== 1'b1 && n < 4) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (n == 4) begin
      errors++;
      report_and_stop();
    end
    rv = rdat;
    re = err;
  endtask : od
  function bit lvl(int k);
    return fen[k] ? fv[k] : lv[k] ^ inv[k];
  endfunction : lvl
  function bit src(bit [7:0] c);
    int s;
    bit v;
    s = c[6:0];
    v = 0;
    if (s >= 1 && s <= 16) v = lvl(s - 1);
    else if (s >= 65 && s <= 70) v = lv[16 + s - 65];
    return v ^ c[7];
  endfunction : src
  function bit [31:0] expin();
    bit [31:0] r;
    r = 0;
    for (int i = 0; i < 32; i++) begin
      if (rte) r[i] = src(tbl[i]);
      else if (i >= 16) r[i] = lvl(i - 16);
      else if (i < 3) r[i] = lvl(i) & msk[i];
    end
    return r;
  endfunction : expin
  task setin();
    lv <= 22'($random(seed));
    repeat (3 * SC) @(posedge i_clk);
    #1;
    chk("input_word", iw, expin());
  endtask : setin
  task chkout();
    bit [31:0] e;
    repeat (3) @(posedge i_clk);
    #1;
    e = men & mval | ~men & (owd ^ pol);
    chk("dio_out", dout, e[19:16]);
    chk("oe_n", doe, {28'h0, ~pio});
    chk("pin", pin, e[19:16] & pio);
    chk("brake_oe_n", bkoe, !e[0]);
    chk("brake_pin", bpin, !e[0]);
  endtask : chkout
  initial begin
    repeat (60000) @(posedge i_clk);
    errors++;
    report_and_stop();
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    seed = 32'h9aa860c8;
    {errors, compares, rte, wr, rd, ix, sb, wd, lv, pio, i_rst_n} = 0;
    {owd, pol, men, mval, msk, inv, fen, fv} = 0;
    foreach (tbl[i]) tbl[i] = 0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1;
    for (int s = 2; s < 5; s++) begin
      od(0, DIOR_IDX_OUT_CFG, 8'(s), 0);
      chk("out_cfg", rv, 0);
    end
    od(0, DIOR_IDX_IN_CFG, DIOR_SUB_8, 0);
    chk("route_en", rv, 0);
    chk("routing_on", ron, 0);
    od(1, DIOR_IDX_OUT_CFG, DIOR_SUB_5, 32'hffff_ffff);
    od(0, DIOR_IDX_OUT_CFG, DIOR_SUB_5, 0);
    chk("compat_err", re, 0);
    chk("compat", rv, 0);
    od(0, 16'h1234, DIOR_SUB_1, 0);
    chk("unmapped_err", re, 1);
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      {owd, pol, men, mval} = {$random(seed), $random(seed), $random(seed), $random(seed)};
      @(posedge i_clk);
      pio <= 4'($random(seed));
      od(1, DIOR_IDX_OUT_WORD, DIOR_SUB_1, owd);
      od(1, DIOR_IDX_OUT_CFG, DIOR_SUB_2, pol);
      od(1, DIOR_IDX_OUT_CFG, DIOR_SUB_3, men);
      od(1, DIOR_IDX_OUT_CFG, DIOR_SUB_4, mval);
      od(1, DIOR_IDX_OUT_CFG, i[0] ? DIOR_SUB_1 : DIOR_SUB_5, $random(seed));
      chkout();
    end
    @(posedge i_clk);
    pio <= 0;
    $display("test outputs done");
    for (int i = 0; i < 12; i++) begin
      {msk, inv, fen, fv} = {$random(seed), $random(seed), $random(seed), $random(seed)};
      od(1, DIOR_IDX_IN_CFG, DIOR_SUB_1, msk);
      od(1, DIOR_IDX_IN_CFG, DIOR_SUB_2, inv);
      od(1, DIOR_IDX_IN_CFG, DIOR_SUB_3, fen);
      od(1, DIOR_IDX_IN_CFG, DIOR_SUB_4, fv);
      setin();
    end
    $display("test inputs done");
    od(1, DIOR_IDX_IN_CFG, DIOR_SUB_8, DIOR_ROUTE_ON);
    rte = 1;
    for (int i = 0; i < 32; i++) tbl[i] = i >= 16 ? 8'(i - 15) : (i < 3 && msk[i]) ? 8'(i + 1) : 0;
    repeat (2) @(posedge i_clk);
    #1;
    chk("input_word", iw, expin());
    chk("routing_on", ron, 1);
    od(0, DIOR_IDX_ROUTE_TBL, 8'h11, 0);
    chk("table", rv, 1);
    for (int c = 0; c < 256; c++) begin
      // Constant one lands on bit 0 so the constant-one check gets exercised
      b = (c == 128) ? 0 : $random(seed) & 31;
      tbl[b] = 8'(c);
      od(1, DIOR_IDX_ROUTE_TBL, 8'(b + 1), c);
      setin();
    end
    $display("test routing done");
    // Routing is left only once, with a value other than one
    od(1, DIOR_IDX_IN_CFG, DIOR_SUB_8, 2);
    rte = 0;
    setin();
    chk("routing_on", ron, 0);
    $display("test routing off done");
    report_and_stop();
  end
endmodule : dior_top_tb
`default_nettype wire
